// ### fsha_pkg.sv
package fsha_pkg;

  localparam int          FSHA_AW        = 12;
  localparam int          FSHA_DW        = 32;

  // ==========================================================
  // Register offsets.
  localparam logic [11:0] FSHA_HANDLER   = 12'hd24;
  localparam logic [11:0] FSHA_FAULT     = 12'hd28;
  localparam logic [11:0] FSHA_MEM_VIEW  = 12'hd28;
  localparam logic [11:0] FSHA_BUS_VIEW  = 12'hd29;
  localparam logic [11:0] FSHA_USG_VIEW  = 12'hd2a;
  localparam logic [11:0] FSHA_MEM_ADDR  = 12'hd34;
  localparam logic [11:0] FSHA_BUS_ADDR  = 12'hd38;
  localparam logic [11:0] FSHA_INT_STAT  = 12'hd40;
  localparam logic [11:0] FSHA_INT_MASK  = 12'hd44;

  // ==========================================================
  // Handler state fields.
  localparam int          FSHA_SVC_BIT   = 7;
  localparam int          FSHA_USG_BIT   = 3;
  localparam int          FSHA_BUS_BIT   = 1;
  localparam int          FSHA_MEM_BIT   = 0;
  localparam int          FSHA_ACT_N     = 4;
  localparam logic [3:0]  FSHA_ACT_RESET = 4'h0;

  // ==========================================================
  // Fault status fields.
  localparam int          FSHA_USG_LSB   = 16;
  localparam int          FSHA_BUS_LSB   = 8;
  localparam int          FSHA_MEM_LSB   = 0;
  localparam int          FSHA_MEM_VALID = 7;
  localparam int          FSHA_BUS_VALID = 15;
  localparam logic [31:0] FSHA_FS_IMPL   = 32'h030f_bf9b;
  localparam logic [31:0] FSHA_FS_RESET  = 32'h0000_0000;
  localparam logic [31:0] FSHA_ADDR_RST  = 32'h0000_0000;

  // ==========================================================
  // Interrupt status fields.
  localparam int          FSHA_INT_N     = 3;
  localparam logic [2:0]  FSHA_INT_RESET = 3'h0;

endpackage : fsha_pkg

// ### fsha_w1c_bank.sv
`timescale 1ns/1ns
`default_nettype none
module fsha_w1c_bank #(
  parameter int          WIDTH = 32,
  parameter logic [31:0] IMPL  = 32'hffff_ffff
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic [WIDTH-1:0] clr_bits,
  output var  logic [WIDTH-1:0] flags_q
);
  import fsha_pkg::*;

  wire [WIDTH-1:0] flags_d;

  // The bit loop below and the IMPL mask serve at most one word.
  if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
    $error("fsha_w1c_bank: WIDTH must lie in 1..32");
  end

  // ==========================================================
  // Sticky bits: a set in the clearing cycle wins over the clear.
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      if (IMPL[g]) begin : g_impl
        assign flags_d[g] = set_bits[g] | (flags_q[g] & ~clr_bits[g]);
      end else begin : g_resv
        assign flags_d[g] = 1'b0;
      end
    end
  endgenerate

  // One process owns the whole flag word; unused bits stay at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end
endmodule // fsha_w1c_bank
`default_nettype wire

// ### fsha_top.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module fsha_top (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [fsha_pkg::FSHA_AW-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  input  wire logic [2:0]               pprot,
  output var  logic [31:0]              prdata,
  output var  logic                     pready,
  output var  logic                     pslverr,
  input  wire logic [31:0]              fault_set,
  input  wire logic                     mem_addr_capture,
  input  wire logic [31:0]              mem_addr_in,
  input  wire logic                     bus_addr_capture,
  input  wire logic [31:0]              bus_addr_in,
  input  wire logic [3:0]               active_set,
  input  wire logic [3:0]               active_clr,
  output var  logic [3:0]               handler_active,
  output var  logic                     irq
);
  import fsha_pkg::*;

  // ==========================================================
  // Bus phases: one wait state, effects at the completing edge.
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic [3:0]  act_q;
  logic [3:0]  act_d;
  logic [31:0] mem_addr_q;
  logic [31:0] bus_addr_q;
  logic [2:0]  imask_q;
  logic [31:0] fs_q;
  logic [2:0]  ist_q;
  logic        irq_q;

  wire         acc       = psel & penable;
  wire         acc_first = acc & ~pready_q;
  wire         done      = acc & pready_q;
  wire         priv      = pprot[0];
  wire [11:0]  word_addr = {paddr[11:2], 2'b00};

  wire         sel_hs    = (word_addr == FSHA_HANDLER);
  wire         sel_fs    = (word_addr == FSHA_FAULT);
  wire         sel_ma    = (word_addr == FSHA_MEM_ADDR);
  wire         sel_ba    = (word_addr == FSHA_BUS_ADDR);
  wire         sel_is    = (word_addr == FSHA_INT_STAT);
  wire         sel_im    = (word_addr == FSHA_INT_MASK);
  wire         sel_any   = sel_hs | sel_fs | sel_ma | sel_ba | sel_is | sel_im;
  // Fault views and their captured addresses refuse user-mode access.
  wire         needs_pv  = sel_fs | sel_ma | sel_ba;
  wire         refuse    = ~sel_any | (needs_pv & ~priv);
  wire         wr_ok     = done & pwrite & ~pslverr_q;

  // Byte lanes: the sub-word views of the fault word map onto pstrb.
  wire [31:0]  lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                            {8{pstrb[1]}}, {8{pstrb[0]}}};

  // ==========================================================
  // Handler active bits: index 0 memory, 1 bus, 2 usage, 3 call.
  wire         hs_wr     = wr_ok & sel_hs & pstrb[0];
  wire [3:0]   hs_wbits  = {pwdata[FSHA_SVC_BIT], pwdata[FSHA_USG_BIT],
                            pwdata[FSHA_BUS_BIT], pwdata[FSHA_MEM_BIT]};
  wire [3:0]   act_sw    = hs_wr ? hs_wbits : act_q;

  always_comb begin
    act_d = (act_sw & ~active_clr) | active_set;
  end

  wire [31:0]  hs_rd;
  assign hs_rd = {24'h00_0000, act_q[3], 3'h0, act_q[2], 1'b0,
                  act_q[1], act_q[0]};

  // ==========================================================
  // Fault status word with its three views and valid flags.
  wire         fs_wr     = wr_ok & sel_fs;
  wire [31:0]  fs_clr    = fs_wr ? (pwdata & lane_mask) : 32'h0;
  wire [31:0]  fs_valid  = ({31'h0, mem_addr_capture} << FSHA_MEM_VALID) |
                           ({31'h0, bus_addr_capture} << FSHA_BUS_VALID);
  wire [31:0]  fs_set    = (fault_set | fs_valid) & FSHA_FS_IMPL;

  fsha_w1c_bank #(
    .WIDTH (32),
    .IMPL  (FSHA_FS_IMPL)
  ) u_fault_bank (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_bits (fs_set),
    .clr_bits (fs_clr),
    .flags_q  (fs_q)
  );

  wire [15:0]  usg_view  = fs_q[31:FSHA_USG_LSB];
  wire [7:0]   bus_view  = fs_q[FSHA_USG_LSB-1:FSHA_BUS_LSB];
  wire [7:0]   mem_view  = fs_q[FSHA_BUS_LSB-1:FSHA_MEM_LSB];
  wire [31:0]  fs_rd     = {usg_view, bus_view, mem_view};

  // ==========================================================
  // Interrupt status: one sticky bit per view gaining a new cause.
  wire [2:0]   int_ev    = {|fs_set[31:16], |fs_set[15:8], |fs_set[7:0]};
  wire [2:0]   int_clr   = (wr_ok & sel_is & pstrb[0]) ? pwdata[2:0] : 3'h0;

  fsha_w1c_bank #(
    .WIDTH (FSHA_INT_N),
    .IMPL  (32'h0000_0007)
  ) u_int_bank (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_bits (int_ev),
    .clr_bits (int_clr),
    .flags_q  (ist_q)
  );

  // ==========================================================
  // Read data selection.
  wire [31:0]  rd_mux =
      sel_hs ? hs_rd :
      sel_fs ? fs_rd :
      sel_ma ? mem_addr_q :
      sel_ba ? bus_addr_q :
      sel_is ? {29'h0, ist_q} :
      sel_im ? {29'h0, imask_q} : 32'h0;

  // ==========================================================
  // Registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc_first;
      pslverr_q <= acc_first & refuse;
      if (acc_first) begin
        prdata_q <= (refuse | pwrite) ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q <= FSHA_ACT_RESET;
    end else begin
      act_q <= act_d;
    end
  end

  // Captures overwrite freely; a later fault replaces the address.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr_q <= FSHA_ADDR_RST;
      bus_addr_q <= FSHA_ADDR_RST;
    end else begin
      if (mem_addr_capture) begin
        mem_addr_q <= mem_addr_in;
      end
      if (bus_addr_capture) begin
        bus_addr_q <= bus_addr_in;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_q <= FSHA_INT_RESET;
      irq_q   <= 1'b0;
    end else begin
      if (wr_ok & sel_im & pstrb[0]) begin
        imask_q <= pwdata[2:0];
      end
      irq_q <= |(ist_q & imask_q);
    end
  end

  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign prdata         = prdata_q;
  assign handler_active = act_q;
  assign irq            = irq_q;

  // ==========================================================
  // Checks.
  sequence s_fs_write;
    psel & penable & pready & pwrite & sel_fs & priv;
  endsequence

  sequence s_hs_read;
    psel & penable & pready & ~pwrite & sel_hs;
  endsequence

  chk_svc_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (hs_wr & ~active_set[3] & ~active_clr[3])
      |=> (handler_active[3] == $past(pwdata[FSHA_SVC_BIT])))
    else $error("Call active bit did not follow the write.");

  chk_usage_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_hs_read |-> (prdata[FSHA_USG_BIT] == $past(handler_active[2])))
    else $error("Usage active bit read back wrong.");

  chk_bus_active_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    active_set[1] |=> handler_active[1])
    else $error("Bus active bit not set by the core.");

  chk_mem_active_clr: assert property (
    @(posedge pclk) disable iff (!presetn)
    (active_clr[0] & ~active_set[0] & ~hs_wr) |=> ~handler_active[0])
    else $error("Memory active bit not cleared.");

  chk_reserved_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_hs_read |-> (prdata[6:4] == 3'h0 && prdata[2] == 1'b0))
    else $error("Reserved handler bits read nonzero.");

  chk_user_refused: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel & penable & pready & needs_pv & ~priv) |-> pslverr)
    else $error("User access to fault status not refused.");

  chk_fault_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel & penable & pready & ~pwrite & sel_fs & priv)
      |-> (prdata == $past(fs_q)))
    else $error("Fault status read does not match its views.");

  chk_w1c_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_fs_write ##0 (fault_set == 32'h0 && !mem_addr_capture
                     && !bus_addr_capture))
      |=> ((fs_q & $past(fs_clr)) == 32'h0))
    else $error("Written one did not clear a fault bit.");

  chk_zero_keeps: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_fs_write ##0 (fault_set == 32'h0))
      |=> ((fs_q & ~$past(fs_clr))
           == (($past(fs_q) | $past(fs_set)) & ~$past(fs_clr))))
    else $error("Written zero changed a fault bit.");

  chk_valid_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    mem_addr_capture |=> (fs_q[FSHA_MEM_VALID]
                          && mem_addr_q == $past(mem_addr_in)))
    else $error("Address capture missed value or valid flag.");

  chk_one_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    (acc & ~pready) |=> pready)
    else $error("Access did not complete after one wait state.");

  chk_refused_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (acc & pready & pslverr) |-> (prdata == 32'h0000_0000))
    else $error("Refused access returned nonzero data.");

  chk_user_no_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (acc && pready && pwrite && sel_fs && !priv && fault_set == 32'h0
     && !mem_addr_capture && !bus_addr_capture)
      |=> (fs_q == $past(fs_q)))
    else $error("User write changed the fault status.");

  chk_write_no_data: assert property (
    @(posedge pclk) disable iff (!presetn)
    (acc & pready & pwrite) |-> (prdata == 32'h0000_0000))
    else $error("Write returned nonzero read data.");

  chk_set_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    fault_set[FSHA_MEM_LSB] |=> fs_q[FSHA_MEM_LSB])
    else $error("Fault cause lost against a clear.");

  chk_bus_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    bus_addr_capture |=> (fs_q[FSHA_BUS_VALID]
                          && bus_addr_q == $past(bus_addr_in)))
    else $error("Bus address capture missed value or flag.");

  chk_byte_lane: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_fs_write ##0 (pstrb == 4'h1 && fault_set == 32'h0
                     && !bus_addr_capture))
      |=> (fs_q[31:8] == $past(fs_q[31:8])))
    else $error("Byte write to memory view touched other views.");

  chk_usage_lanes: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_fs_write ##0 (pstrb == 4'hc && fault_set == 32'h0
                     && !mem_addr_capture && !bus_addr_capture))
      |=> (fs_q[15:0] == $past(fs_q[15:0])))
    else $error("Usage halfword write touched lower views.");

  chk_handler_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (hs_wr && active_set == 4'h0 && active_clr == 4'h0)
      |=> (handler_active[2:0] == {$past(pwdata[FSHA_USG_BIT]),
                                   $past(pwdata[FSHA_BUS_BIT]),
                                   $past(pwdata[FSHA_MEM_BIT])}))
    else $error("Handler active bits did not follow the write.");

  chk_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq == $past(|(ist_q & imask_q)))
    else $error("Interrupt line does not follow status and mask.");

endmodule // fsha_top
`default_nettype wire

// ### test_fault_status_and_handler_active.sv
`timescale 1ns/1ns
`default_nettype none
module test_fault_status_and_handler_active;
  import fsha_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, fault_set, mem_addr_in, bus_addr_in;
  logic [3:0]  pstrb, active_set, active_clr, handler_active;
  logic [2:0]  pprot;
  logic        pready, pslverr, mem_addr_capture, bus_addr_capture, irq;
  int          n_errors, compares, cyc;
  logic [31:0] rdat;
  logic        rerr;

  fsha_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_set(fault_set),
    .mem_addr_capture(mem_addr_capture), .mem_addr_in(mem_addr_in),
    .bus_addr_capture(bus_addr_capture), .bus_addr_in(bus_addr_in),
    .active_set(active_set), .active_clr(active_clr),
    .handler_active(handler_active), .irq(irq));

  always #2 pclk = ~pclk;

  // ==========================================================
  // Checking and bus tasks.
  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // The request stays put until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     input logic [2:0] p);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a;
    pwdata <= d; pstrb <= s; pprot <= p;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    apb(1'b1, a, d, s, 3'h1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [2:0] p,
                    input logic [31:0] e, input logic ee, input string nm);
    apb(1'b0, a, 32'h0, 4'h0, p);
    chk(nm, e, rdat);
    chk({nm, " err"}, {31'h0, ee}, {31'h0, rerr});
  endtask

  task automatic pulse_fault(input logic [31:0] v);
    @(posedge pclk);
    fault_set <= v;
    @(posedge pclk);
    fault_set <= 32'h0;
  endtask

  // ==========================================================
  // Scenarios.
  task automatic t_handler();
    rd(FSHA_HANDLER, 3'h1, 32'h0, 1'b0, "handler reset");
    apb(1'b1, FSHA_HANDLER, 32'hff, 4'h1, 3'h0);
    rd(FSHA_HANDLER, 3'h0, 32'h8b, 1'b0, "handler all");
    chk("active all", 32'hf, {28'h0, handler_active});
    wr(FSHA_HANDLER, 32'h08, 4'h1);
    idle(2);
    chk("active usage", 32'h4, {28'h0, handler_active});
    wr(FSHA_HANDLER, 32'h0, 4'h1);
    @(posedge pclk) active_set <= 4'h3;
    @(posedge pclk) active_set <= 4'h0;
    idle(2);
    rd(FSHA_HANDLER, 3'h1, 32'h03, 1'b0, "core active");
    @(posedge pclk) active_clr <= 4'h1;
    @(posedge pclk) active_clr <= 4'h0;
    idle(2);
    chk("core bus only", 32'h2, {28'h0, handler_active});
    wr(FSHA_HANDLER, 32'h0, 4'h1);
    $display("test handler done");
  endtask

  task automatic t_views();
    logic [11:0] av [5];
    logic [3:0]  sv [5];
    logic [31:0] m;
    av = '{12'hd28, 12'hd29, 12'hd28, 12'hd2a, 12'hd28};
    sv = '{4'h1, 4'h2, 4'h3, 4'hc, 4'hf};
    rd(FSHA_FAULT, 3'h1, FSHA_FS_RESET, 1'b0, "fault reset");
    for (int i = 0; i < 5; i++) begin
      m = {{8{sv[i][3]}}, {8{sv[i][2]}}, {8{sv[i][1]}}, {8{sv[i][0]}}};
      pulse_fault(32'hffff_ffff);
      wr(av[i], 32'hffff_ffff, sv[i]);
      rd(FSHA_FAULT, 3'h1, FSHA_FS_IMPL & ~m, 1'b0, "view");
      wr(FSHA_FAULT, 32'hffff_ffff, 4'hf);
    end
    pulse_fault(32'hffff_ffff);
    wr(FSHA_FAULT, 32'h0001_0101, 4'hf);
    rd(FSHA_FAULT, 3'h1, FSHA_FS_IMPL & ~32'h0001_0101, 1'b0,
       "w1c bits");
    apb(1'b1, FSHA_FAULT, 32'hffff_ffff, 4'hf, 3'h0);
    chk("user write err", 32'h1, {31'h0, rerr});
    rd(FSHA_FAULT, 3'h0, 32'h0, 1'b1, "user read");
    rd(FSHA_FAULT, 3'h1, FSHA_FS_IMPL & ~32'h0001_0101, 1'b0,
       "kept");
    rd(12'hd30, 3'h1, 32'h0, 1'b1, "unmapped");
    wr(FSHA_FAULT, 32'hffff_ffff, 4'hf);
    $display("test views done");
  endtask

  task automatic t_addr();
    @(posedge pclk);
    mem_addr_capture <= 1'b1; mem_addr_in <= 32'h2000_0010;
    @(posedge pclk);
    mem_addr_capture <= 1'b0;
    rd(FSHA_MEM_ADDR, 3'h1, 32'h2000_0010, 1'b0, "mem addr");
    rd(FSHA_FAULT, 3'h1, 32'h80, 1'b0, "mem valid");
    @(posedge pclk);
    mem_addr_capture <= 1'b1; mem_addr_in <= 32'h2000_0044;
    bus_addr_capture <= 1'b1; bus_addr_in <= 32'h4000_0008;
    @(posedge pclk);
    mem_addr_capture <= 1'b0;
    bus_addr_capture <= 1'b0;
    rd(FSHA_MEM_ADDR, 3'h1, 32'h2000_0044, 1'b0, "overwrite");
    rd(FSHA_BUS_ADDR, 3'h1, 32'h4000_0008, 1'b0, "bus addr");
    rd(FSHA_FAULT, 3'h1, 32'h8080, 1'b0, "both valid");
    rd(FSHA_BUS_ADDR, 3'h0, 32'h0, 1'b1, "user addr");
    wr(FSHA_FAULT, 32'h80, 4'h1);
    rd(FSHA_FAULT, 3'h1, 32'h8000, 1'b0, "bus valid kept");
    wr(FSHA_FAULT, 32'hffff_ffff, 4'hf);
    $display("test addr done");
  endtask

  task automatic t_irq();
    wr(FSHA_INT_STAT, 32'h7, 4'h1);
    wr(FSHA_INT_MASK, 32'h0, 4'h1);
    pulse_fault(32'h0000_0101);
    rd(FSHA_INT_STAT, 3'h1, 32'h3, 1'b0, "int status");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(FSHA_INT_MASK, 32'h1, 4'h1);
    idle(2);
    chk("irq high", 32'h1, {31'h0, irq});
    wr(FSHA_INT_STAT, 32'h1, 4'h1);
    idle(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd(FSHA_INT_STAT, 3'h1, 32'h2, 1'b0, "int left");
    $display("test irq done");
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0; pstrb = 4'h0;
    pprot = 3'h0; fault_set = 32'h0; mem_addr_capture = 1'b0;
    mem_addr_in = 32'h0; bus_addr_capture = 1'b0; bus_addr_in = 32'h0;
    active_set = 4'h0; active_clr = 4'h0;
    n_errors = 0; compares = 0; cyc = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_handler();
    t_views();
    t_addr();
    t_irq();
    print_verdict();
  end
endmodule // test_fault_status_and_handler_active
`default_nettype wire
